// file: tb/rca_far_end.sv
/*
 far side of the arbiter: terminal block contacts and keypad keys.
 assumes the bench sets wanted levels by non-blocking assignment at a clock edge.
*/
module rca_far_end
	import rca_pkg::*;
(
	// clock
	input  wire logic         aclk,
	// wanted levels from the bench
	input  rca_pkg::rca_term_t want_term,
	input  rca_pkg::rca_keys_t want_keys,
	// pins to the arbiter
	output rca_pkg::rca_term_t term,
	output rca_pkg::rca_keys_t keys
);
	timeunit 1ns;
	timeprecision 1ps;
	// contacts move only just after an edge, so the arbiter never sees a mid-cycle glitch
	always_ff @(posedge aclk) begin
		term <= want_term;
		keys <= want_keys;
	end
endmodule

// file: tb/run_command_arbiter_tb.sv
/*
 self-checking bench of the run command arbiter: axi4-lite tasks and pin sequences.
 assumes the default parameters: power-on run and restart after reset both off.
*/
`include "rca_map.svh"
module run_command_arbiter_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rca_pkg::*;

	logic               aclk;
	logic               aresetn;
	logic [`RCA_AW-1:0] awaddr;
	logic               awvalid;
	logic               awready;
	logic [31:0]        wdata;
	logic [3:0]         wstrb;
	logic               wvalid;
	logic               wready;
	logic [1:0]         bresp;
	logic               bvalid;
	logic               bready;
	logic [`RCA_AW-1:0] araddr;
	logic               arvalid;
	logic               arready;
	logic [31:0]        rdata;
	logic [1:0]         rresp;
	logic               rvalid;
	logic               rready;
	rca_term_t          term;
	rca_term_t          want_term;
	rca_keys_t          keys;
	rca_keys_t          want_keys;
	logic               run_enable_input;
	logic               fault_trip;
	logic               fault_reset;
	logic               motor_run;
	logic               motor_rev;
	logic               local_mode;
	logic               keypad_src_ind;
	logic [31:0]        d;
	logic [1:0]         r;
	int                 n_fail;
	int                 compares;

	rca_arbiter i_rca_arbiter (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .term(term),
		.keys(keys), .run_enable_input(run_enable_input), .fault_trip(fault_trip),
		.fault_reset(fault_reset), .motor_run(motor_run), .motor_rev(motor_rev),
		.local_mode(local_mode), .keypad_src_ind(keypad_src_ind));

	rca_far_end i_rca_far_end (.aclk(aclk), .want_term(want_term),
		.want_keys(want_keys), .term(term), .keys(keys));

	always #12.5 aclk = ~aclk;

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// run, direction, local flag
	task automatic out(input logic [2:0] e);
		chk({29'h0, motor_run, motor_rev, local_mode}, {29'h0, e});
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		while (bvalid !== 1'b1) @(posedge aclk);
		r = bresp;
		bready <= 1'b0;
		step(2);
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge aclk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// far side picks the levels up one edge later, the arbiter one more
	task automatic drive(input logic [4:0] t, input logic [3:0] k);
		@(posedge aclk);
		want_term <= t;
		want_keys <= k;
		step(4);
	endtask

	task automatic press(input logic [4:0] t, input logic [3:0] k);
		drive(t, k);
		drive(t, 4'h0);
	endtask

	task automatic trip_and_reset;
		@(posedge aclk);
		fault_trip <= 1'b1;
		step(4);
		chk(32'(motor_run), 32'h0);
		@(posedge aclk);
		fault_trip <= 1'b0;
		fault_reset <= 1'b1;
		step(4);
		@(posedge aclk);
		fault_reset <= 1'b0;
		step(4);
	endtask

	initial begin
		repeat (4000) @(posedge aclk);
		n_fail++;
		stop_test;
	end

	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
		wstrb = 4'hf;
		want_term = 5'h10;
		want_keys = 4'h0;
		run_enable_input = 1'b1;
		fault_trip = 1'b0;
		fault_reset = 1'b0;
		n_fail = 0;
		compares = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		step(4);
		// forward held through power-up
		out(3'b000);
		rd(`RCA_OFF_CTRL);
		chk(d, {22'h0, `RCA_CTRL_INIT});
		rd(`RCA_OFF_STAT);
		chk(32'(d[`RCA_STAT_PWRBLK]), 32'h1);
		drive(5'h00, 4'h0);
		drive(5'h10, 4'h0);
		out(3'b100);
		drive(5'h18, 4'h0);
		out(3'b000);
		$display("test power-up gating done");
		wr(`RCA_OFF_CTRL, 32'h0000_0002);
		step(2);
		out(3'b110);
		wr(`RCA_OFF_CTRL, 32'h0000_0042);
		chk(32'(motor_run), 32'h0);
		wr(`RCA_OFF_CTRL, 32'h0000_0022);
		out(3'b110);
		drive(5'h10, 4'h0);
		chk(32'(motor_run), 32'h0);
		wr(`RCA_OFF_CTRL, 32'h0000_0002);
		out(3'b100);
		$display("test modes and inhibit done");
		wr(`RCA_OFF_CTRL, 32'h0000_0009);
		out(3'b100);
		press(5'h10, 4'h1);
		out(3'b001);
		chk(32'(keypad_src_ind), 32'h1);
		press(5'h10, 4'h8);
		out(3'b101);
		drive(5'h08, 4'h0);
		out(3'b101);
		press(5'h08, 4'h1);
		out(3'b110);
		chk(32'(keypad_src_ind), 32'h0);
		$display("test local and remote done");
		wr(`RCA_OFF_CTRL, 32'h0000_000b);
		wr(`RCA_OFF_SCMD, 32'h0000_0003);
		chk(32'(r), 32'(`RCA_RESP_OKAY));
		out(3'b110);
		wr(`RCA_OFF_SCMD, 32'h0000_0000);
		chk(32'(motor_run), 32'h0);
		wr(`RCA_OFF_SCMD, 32'h0000_0001);
		out(3'b100);
		press(5'h08, 4'h1);
		chk(32'(motor_run), 32'h0);
		press(5'h08, 4'h8);
		out(3'b101);
		press(5'h08, 4'h1);
		chk(32'(motor_run), 32'h0);
		wr(`RCA_OFF_SCMD, 32'h0000_0001);
		out(3'b100);
		$display("test serial source done");
		wr(`RCA_OFF_CTRL, 32'h0000_0009);
		drive(5'h10, 4'h0);
		out(3'b100);
		trip_and_reset();
		out(3'b000);
		drive(5'h00, 4'h0);
		drive(5'h10, 4'h0);
		out(3'b100);
		wr(`RCA_OFF_CTRL, 32'h0000_0109);
		trip_and_reset();
		out(3'b100);
		wr(`RCA_OFF_CTRL, 32'h0000_0209);
		out(3'b100);
		@(posedge aclk);
		run_enable_input <= 1'b0;
		step(2);
		chk(32'(motor_run), 32'h0);
		@(posedge aclk);
		run_enable_input <= 1'b1;
		step(2);
		out(3'b100);
		wr(`RCA_OFF_CTRL, 32'h0000_0000);
		out(3'b000);
		chk(32'(keypad_src_ind), 32'h1);
		press(5'h10, 4'h4);
		out(3'b110);
		press(5'h10, 4'h2);
		out(3'b010);
		wr(4'hc, 32'h0000_0001);
		chk(32'(r), 32'(`RCA_RESP_SLVERR));
		rd(`RCA_OFF_CTRL);
		chk(d, `RCA_ZERO);
		rd(4'hc);
		chk(d, `RCA_ZERO);
		chk(32'(r), 32'(`RCA_RESP_SLVERR));
		$display("test fault reset and bus done");
		stop_test;
	end
endmodule

// file: verilog/rca_arbiter.sv
/*
 run command arbiter: picks keypad, terminal or serial commands, local/remote
 toggle, direction inhibit, power-up and fault-reset gating; axi4-lite registers.
 assumes all pins synchronous to aclk and a single-outstanding axi4-lite master.
*/
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
// Operation
// RULE_01: source value 3 takes run, stop and direction from the serial host.
// RULE_02: local mode: keypad owns commands, inch ignored, run enable still required.
// RULE_03: multi-key selection 1: a key press toggles remote to local.
// RULE_04: another press in local returns to remote and the configured source.
// RULE_05: remote runs from the configured sources, no settings changed.
// RULE_06: remote to local stops a remote run; indicator shows keypad source.
// RULE_07: local to remote with terminal source follows terminals at once.
// RULE_08: local to remote with digital source stops, waits for next command.
// RULE_09: power-on run off: any of five inputs active at power-up blocks terminals.
// RULE_10: blocked terminals still allow keypad running in local mode.
// RULE_11: after fault reset terminals wait for all-off then on; local keypad runs.
// RULE_12: direction inhibit: 0 none, 1 blocks forward, 2 blocks reverse.
// RULE_13: power-on run on: active terminal command runs at power-up, modes 1-2.
// RULE_14: power-on run off: terminal command must drop and rise again.
// RULE_15: restart after reset on: still-active terminal command resumes at once.
// RULE_16: restart off: run needs the command dropped and raised after reset.
// RULE_17: terminal mode 1: both or neither run input active means stop.
// RULE_18: terminal mode 2: forward is run, reverse selects direction.
// RULE_19: run and key requests are qualified by edges against last cycle; only keypad keys are, terminal run inputs act as levels.
// RULE_20: inhibited direction keeps motor stopped, arbitration state untouched.
`include "rca_map.svh"
module rca_arbiter #(
	parameter bit P_PWR_ON_RUN = 1'b0,
	parameter bit P_RST_RESTART = 1'b0
) (
	// clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// axi4-lite slave
	input  wire logic [`RCA_AW-1:0]   awaddr,
	input  wire logic                 awvalid,
	output logic                      awready,
	input  wire logic [31:0]          wdata,
	input  wire logic [3:0]           wstrb,
	input  wire logic                 wvalid,
	output logic                      wready,
	output logic [1:0]                bresp,
	output logic                      bvalid,
	input  wire logic                 bready,
	input  wire logic [`RCA_AW-1:0]   araddr,
	input  wire logic                 arvalid,
	output logic                      arready,
	output logic [31:0]               rdata,
	output logic [1:0]                rresp,
	output logic                      rvalid,
	input  wire logic                 rready,
	// terminal block, keypad, run enable, fault
	input  rca_pkg::rca_term_t        term,
	input  rca_pkg::rca_keys_t        keys,
	input  wire logic                 run_enable_input,
	input  wire logic                 fault_trip,
	input  wire logic                 fault_reset,
	// to ramp logic and display
	output logic                      motor_run,
	output logic                      motor_rev,
	output logic                      local_mode,
	output logic                      keypad_src_ind
);
	import rca_pkg::*;

	localparam logic [`RCA_CW-1:0] CTRL_RST = `RCA_CTRL_INIT
		| ({{(`RCA_CW-1){1'b0}}, P_PWR_ON_RUN} << `RCA_CTRL_PWR)
		| ({{(`RCA_CW-1){1'b0}}, P_RST_RESTART} << `RCA_CTRL_RST);

	rca_state_t s_q, s_d;
	logic [3:0] key_rise;
	logic       t_run, t_rev, t_any, t_pwr;
	logic       wr_hs, rd_hs;

	function automatic logic is_term(input logic [2:0] src);
		return (src == `RCA_SRC_TERM1) || (src == `RCA_SRC_TERM2);
	endfunction

	// inhibited direction only masks the output, the latches stay as they are
	function automatic logic dir_ok(input logic [1:0] prev, input logic rev);
		return !((prev == `RCA_PREV_FWD && !rev) || (prev == `RCA_PREV_REV && rev));
	endfunction

	function automatic logic [31:0] rd_word(input rca_state_t s, input logic [`RCA_AW-1:0] a);
		logic [31:0] w;
		w = `RCA_ZERO;
		unique case (a)
			`RCA_OFF_CTRL: w[`RCA_CW-1:0] = s.ctrl;
			`RCA_OFF_SCMD: w[`RCA_SCMD_REV:`RCA_SCMD_RUN] = s.scmd;
			`RCA_OFF_STAT: begin
				w[`RCA_STAT_RUN]    = s.run;
				w[`RCA_STAT_REV]    = s.dir_rev;
				w[`RCA_STAT_LOCAL]  = s.local_mode;
				w[`RCA_STAT_PWRBLK] = s.pwr_block;
				w[`RCA_STAT_FLTBLK] = s.flt_block;
				w[`RCA_STAT_FAULT]  = s.fault;
				w[`RCA_STAT_KK]     = s.local_mode || s.ctrl[`RCA_CTRL_SRC] == `RCA_SRC_KEYPAD;
			end
			default: w = `RCA_ZERO;
		endcase
		return w;
	endfunction

	rca_edge #(.W(4)) u_keys (
		.aclk   (aclk),
		.aresetn(aresetn),
		.level  (keys),
		.rise   (key_rise)
	);

	rca_term_decode u_term (
		.src    (s_q.ctrl[`RCA_CTRL_SRC]),
		.term   (term),
		.run    (t_run),
		.rev    (t_rev),
		.any_run(t_any),
		.any_pwr(t_pwr)
	);

	assign wr_hs = awvalid && wvalid && s_q.awready;
	assign rd_hs = arvalid && s_q.arready;

	always_comb begin
		logic [2:0] src;
		logic       tsrc;
		logic       scmd_ev;
		logic       kp_act;
		logic       req_run;
		logic       req_rev;
		src     = s_q.ctrl[`RCA_CTRL_SRC];
		tsrc    = is_term(src);
		scmd_ev = 1'b0;
		req_run = 1'b0;
		req_rev = 1'b0;
		kp_act  = 1'b0;
		s_d     = s_q;

		// write channel: address and data are taken together
		s_d.awready = 1'b0;
		if (s_q.bvalid && bready) begin
			s_d.bvalid = 1'b0;
		end
		if (!s_q.awready && !s_q.bvalid && awvalid && wvalid) begin
			s_d.awready = 1'b1;
		end
		if (wr_hs) begin
			s_d.bvalid = 1'b1;
			s_d.bresp  = `RCA_RESP_OKAY;
			unique case (awaddr)
				`RCA_OFF_CTRL: begin
					if (wstrb[0]) s_d.ctrl[`RCA_CTRL_LO] = wdata[`RCA_CTRL_LO];
					if (wstrb[1]) s_d.ctrl[`RCA_CTRL_HI] = wdata[`RCA_CTRL_HI];
				end
				`RCA_OFF_SCMD: begin
					if (wstrb[0]) begin
						s_d.scmd = wdata[`RCA_SCMD_REV:`RCA_SCMD_RUN];
						scmd_ev  = 1'b1;
					end
				end
				`RCA_OFF_STAT: s_d.bresp = `RCA_RESP_OKAY;
				default:       s_d.bresp = `RCA_RESP_SLVERR;
			endcase
		end

		// read channel
		s_d.arready = 1'b0;
		if (s_q.rvalid && rready) begin
			s_d.rvalid = 1'b0;
		end
		if (!s_q.arready && !s_q.rvalid && arvalid) begin
			s_d.arready = 1'b1;
		end
		if (rd_hs) begin
			s_d.rvalid = 1'b1;
			s_d.rdata  = rd_word(s_q, araddr);
			s_d.rresp  = (araddr == `RCA_OFF_CTRL || araddr == `RCA_OFF_SCMD
				|| araddr == `RCA_OFF_STAT) ? `RCA_RESP_OKAY : `RCA_RESP_SLVERR;
		end

		// first cycle after reset release looks at the terminals once
		if (s_q.init) begin
			s_d.init      = 1'b0;
			s_d.pwr_block = t_pwr && !s_q.ctrl[`RCA_CTRL_PWR]; // [RULE_09] [RULE_13] [RULE_14]
		end else if (s_q.pwr_block && !t_pwr) begin
			s_d.pwr_block = 1'b0; // [RULE_09]
		end

		// fault trip and reset
		if (fault_trip) begin
			s_d.fault = 1'b1;
		end else if (s_q.fault && fault_reset) begin
			s_d.fault     = 1'b0;
			s_d.flt_block = !(s_q.ctrl[`RCA_CTRL_RST] && tsrc); // [RULE_15] [RULE_16]
		end else if (s_q.flt_block && !t_any) begin
			s_d.flt_block = 1'b0; // [RULE_11] [RULE_16]
		end

		// digital command latch: keypad keys
		kp_act = s_q.local_mode || src == `RCA_SRC_KEYPAD;
		if (kp_act) begin // [RULE_02] [RULE_10]
			if (key_rise[1]) begin
				s_d.dig_run = 1'b0;
			end else if (key_rise[3]) begin
				s_d.dig_run = 1'b1;
				s_d.dig_rev = 1'b0;
			end else if (key_rise[2]) begin
				s_d.dig_run = 1'b1;
				s_d.dig_rev = 1'b1;
			end
		end else if (!tsrc && scmd_ev) begin
			// serial host (and any other digital source) drives the latch
			s_d.dig_run = wdata[`RCA_SCMD_RUN]; // [RULE_01]
			s_d.dig_rev = wdata[`RCA_SCMD_REV]; // [RULE_01]
		end
		if (fault_trip || s_q.fault) begin
			s_d.dig_run = 1'b0; // [RULE_16]
		end

		// local/remote toggle; a key press in the same cycle is dropped
		if (key_rise[0] && s_q.ctrl[`RCA_CTRL_MK] == `RCA_MK_LOCREM) begin
			s_d.local_mode = !s_q.local_mode; // [RULE_03] [RULE_04]
			if (!s_q.local_mode) begin
				s_d.dig_run = 1'b0; // [RULE_06]
			end else begin
				// a terminal source never reads the latch; clearing it anyway keeps a
				// stale keypad run from coming back once the source is set to serial
				s_d.dig_run = 1'b0; // [RULE_08]
			end
		end

		// arbitration; configuration is never touched by the toggle
		if (s_d.local_mode || !tsrc) begin // [RULE_05]
			req_run = s_d.dig_run;
			req_rev = s_d.dig_rev;
		end else begin
			// blocks as set this cycle, or the first edge after reset and the
			// fault-reset edge would each let one cycle of run through
			req_run = t_run && !s_d.pwr_block && !s_d.flt_block; // [RULE_07] [RULE_11]
			req_rev = t_rev; // [RULE_07]
		end
		req_run = req_run && !s_d.fault
			&& (!s_q.ctrl[`RCA_CTRL_REN] || run_enable_input); // [RULE_02]
		s_d.run = req_run && dir_ok(s_q.ctrl[`RCA_CTRL_PREV], req_rev); // [RULE_12] [RULE_20]
		if (s_d.run) begin
			s_d.dir_rev = req_rev;
		end
		s_d.kk_ind = s_d.local_mode || s_d.ctrl[`RCA_CTRL_SRC] == `RCA_SRC_KEYPAD; // [RULE_06]
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q      <= '0;
			s_q.ctrl <= CTRL_RST;
			s_q.init <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign awready        = s_q.awready;
	assign wready         = s_q.awready;
	assign bvalid         = s_q.bvalid;
	assign bresp          = s_q.bresp;
	assign arready        = s_q.arready;
	assign rvalid         = s_q.rvalid;
	assign rresp          = s_q.rresp;
	assign rdata          = s_q.rdata;
	assign motor_run      = s_q.run;
	assign motor_rev      = s_q.dir_rev;
	assign local_mode     = s_q.local_mode;
	assign keypad_src_ind = s_q.kk_ind;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic mk_hit;
	assign mk_hit = key_rise[0] && s_q.ctrl[`RCA_CTRL_MK] == `RCA_MK_LOCREM;

	a_toggle_local: assert property ( // [RULE_03]
		mk_hit && !s_q.local_mode |=> s_q.local_mode)
		else $error("multi key did not enter local");
	a_toggle_remote: assert property ( // [RULE_04]
		mk_hit && s_q.local_mode |=> !s_q.local_mode)
		else $error("multi key did not return to remote");
	a_local_stop: assert property ( // [RULE_06]
		$rose(s_q.local_mode) |-> !s_q.run && keypad_src_ind)
		else $error("remote run survived switch to local");
	a_digital_stop: assert property ( // [RULE_08]
		$fell(s_q.local_mode) && !is_term(s_q.ctrl[`RCA_CTRL_SRC]) |-> !s_q.run)
		else $error("digital source kept running on return to remote");
	a_term_follow: assert property ( // [RULE_07]
		s_q.run && !s_q.local_mode && $stable(s_q.ctrl) && is_term(s_q.ctrl[`RCA_CTRL_SRC])
		|-> s_q.dir_rev == $past(term.reverse_run_input))
		else $error("terminal direction not followed");
	a_mode1_stop: assert property ( // [RULE_17]
		!s_q.local_mode && s_q.ctrl[`RCA_CTRL_SRC] == `RCA_SRC_TERM1 && !mk_hit
		&& term.forward_run_input == term.reverse_run_input |=> !s_q.run)
		else $error("mode 1 ran with equal run inputs");
	a_inhibit_dir: assert property ( // [RULE_20]
		s_q.run |-> dir_ok($past(s_q.ctrl[`RCA_CTRL_PREV]), s_q.dir_rev))
		else $error("ran in inhibited direction");
	a_pwr_block: assert property ( // [RULE_09]
		s_q.pwr_block && !s_q.local_mode && !mk_hit && is_term(s_q.ctrl[`RCA_CTRL_SRC])
		|=> !s_q.run)
		else $error("terminal run while power-up block held");
	a_flt_block: assert property ( // [RULE_11]
		s_q.flt_block && !s_q.local_mode && !mk_hit && is_term(s_q.ctrl[`RCA_CTRL_SRC])
		|=> !s_q.run)
		else $error("terminal run while fault block held");
	a_rst_restart: assert property ( // [RULE_15]
		s_q.fault && fault_reset && !fault_trip && s_q.ctrl[`RCA_CTRL_RST]
		&& is_term(s_q.ctrl[`RCA_CTRL_SRC]) |=> !s_q.flt_block)
		else $error("restart after reset still blocked");
	a_bvalid_hold: assert property (
		s_q.bvalid && !bready |=> s_q.bvalid)
		else $error("write response dropped early");
	a_rvalid_hold: assert property (
		s_q.rvalid && !rready |=> s_q.rvalid && $stable(s_q.rdata))
		else $error("read data dropped early");

	// first edge after reset: the block must act before pwr_block shows it
	a_init_block: assert property ( // [RULE_09]
		s_q.init && !s_q.ctrl[`RCA_CTRL_PWR] && t_pwr && !s_q.local_mode
		&& is_term(s_q.ctrl[`RCA_CTRL_SRC]) |=> !s_q.run)
		else $error("terminal run slipped through at power-up");
	// with restart off no source may run in the cycle after a latched fault
	a_fault_hold: assert property ( // [RULE_16]
		s_q.fault && !s_q.ctrl[`RCA_CTRL_RST] |=> !s_q.run)
		else $error("run resumed at fault reset without a new command");
	a_run_enable: assert property ( // [RULE_02]
		s_q.ctrl[`RCA_CTRL_REN] && !run_enable_input |=> !s_q.run)
		else $error("ran without run enable");
	a_serial_cmd: assert property ( // [RULE_01]
		wr_hs && awaddr == `RCA_OFF_SCMD && wstrb[0] && !s_q.local_mode && !mk_hit
		&& s_q.ctrl[`RCA_CTRL_SRC] == `RCA_SRC_SERIAL && !fault_trip && !s_q.fault
		&& !s_q.ctrl[`RCA_CTRL_REN] && dir_ok(s_q.ctrl[`RCA_CTRL_PREV], wdata[`RCA_SCMD_REV])
		|=> s_q.run == $past(wdata[`RCA_SCMD_RUN]))
		else $error("serial command not applied");

	c_local_trip: cover property (mk_hit ##1 s_q.local_mode ##[1:20] s_q.run);
	c_serial_run: cover property (wr_hs && awaddr == `RCA_OFF_SCMD ##1 s_q.run);
	c_fault_rst: cover property (s_q.fault ##1 !s_q.fault ##[1:20] s_q.run);
	c_pwr_release: cover property (s_q.pwr_block ##1 !s_q.pwr_block ##[1:20] s_q.run);
	c_inhibit_run: cover property (s_q.ctrl[`RCA_CTRL_PREV] == `RCA_PREV_FWD && s_q.run);
endmodule

// file: verilog/rca_edge.sv
/*
 rising edge finder for the keypad keys.
 assumes levels synchronous to aclk; output is combinational.
*/
module rca_edge #(
	parameter int W = 4
) (
	// clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// levels in, one-cycle rises out
	input  wire logic [W-1:0] level,
	output logic      [W-1:0] rise
);
	logic [W-1:0] prev_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_q <= '0;
		end else begin
			prev_q <= level;
		end
	end

	// a held key counts once, not every cycle
	assign rise = level & ~prev_q; // [RULE_19]
endmodule

// file: verilog/rca_map.svh
/*
 register map, field positions, encodings and reset values of the run command arbiter.
 assumes inclusion by rca_pkg and the arbiter top; definitions only.
*/
`ifndef RCA_MAP_SVH
`define RCA_MAP_SVH

`define RCA_AW          4
`define RCA_OFF_CTRL    4'h0
`define RCA_OFF_SCMD    4'h4
`define RCA_OFF_STAT    4'h8

`define RCA_CW          10
`define RCA_CTRL_SRC    2:0
`define RCA_CTRL_MK     4:3
`define RCA_CTRL_PREV   6:5
`define RCA_CTRL_PWR    7
`define RCA_CTRL_RST    8
`define RCA_CTRL_REN    9
`define RCA_CTRL_LO     7:0
`define RCA_CTRL_HI     9:8
`define RCA_CTRL_INIT   10'h001

`define RCA_SRC_KEYPAD  3'h0
`define RCA_SRC_TERM1   3'h1
`define RCA_SRC_TERM2   3'h2
`define RCA_SRC_SERIAL  3'h3

`define RCA_MK_LOCREM   2'h1
`define RCA_PREV_FWD    2'h1
`define RCA_PREV_REV    2'h2

`define RCA_SCMD_RUN    0
`define RCA_SCMD_REV    1

`define RCA_STAT_RUN    0
`define RCA_STAT_REV    1
`define RCA_STAT_LOCAL  2
`define RCA_STAT_PWRBLK 3
`define RCA_STAT_FLTBLK 4
`define RCA_STAT_FAULT  5
`define RCA_STAT_KK     6

`define RCA_RESP_OKAY   2'h0
`define RCA_RESP_SLVERR 2'h2
`define RCA_ZERO        32'h0000_0000

`endif

// file: verilog/rca_pkg.sv
/*
 types of the run command arbiter: pin groups and the packed state of the top.
 assumes rca_map.svh on the include path.
*/
`include "rca_map.svh"
package rca_pkg;
	typedef struct packed {
		logic forward_run_input;
		logic reverse_run_input;
		logic forward_inch_input;
		logic reverse_inch_input;
		logic motor_premagnetize_input;
	} rca_term_t;

	typedef struct packed {
		logic fwd_key;
		logic rev_key;
		logic stop_key;
		logic multi_key;
	} rca_keys_t;

	typedef struct packed {
		logic [`RCA_CW-1:0] ctrl;
		logic [1:0]         scmd;
		logic               init;
		logic               pwr_block;
		logic               flt_block;
		logic               fault;
		logic               local_mode;
		logic               dig_run;
		logic               dig_rev;
		logic               run;
		logic               dir_rev;
		logic               kk_ind;
		logic               awready;
		logic               bvalid;
		logic [1:0]         bresp;
		logic               arready;
		logic               rvalid;
		logic [1:0]         rresp;
		logic [31:0]        rdata;
	} rca_state_t;
endpackage

// file: verilog/rca_term_decode.sv
/*
 decodes the terminal-block run inputs for the two terminal modes.
 assumes inputs synchronous to aclk; purely combinational.
*/
`include "rca_map.svh"
module rca_term_decode
	import rca_pkg::*;
(
	// selection and pins
	input  wire logic [2:0]         src,
	input  rca_pkg::rca_term_t      term,
	// decoded request
	output logic                    run,
	output logic                    rev,
	output logic                    any_run,
	output logic                    any_pwr
);
	always_comb begin
		if (src == `RCA_SRC_TERM1) begin
			run = term.forward_run_input ^ term.reverse_run_input; // [RULE_17]
		end else begin
			run = term.forward_run_input; // [RULE_18]
		end
		rev     = term.reverse_run_input; // [RULE_18]
		any_run = term.forward_run_input | term.reverse_run_input;
		any_pwr = |term; // [RULE_09]
	end
endmodule
